// ### pmt_pkg.sv
// Purpose: Shared constants and types of the program memory access block
// Assumes: One 200 MHz clock; program store of 8K words of 16 bits
// Notes: The serial frame layout belongs to the replaceable serial port
//
// What this block does
// - Program store holds 8K words of 16 bits
// - Reset loads program counter with address zero
// - Table address is pointer high joined with low
// - Low byte to data memory, high byte kept
// - Standard forms sector 0, extended reach others
// - Table read lasts exactly two instruction cycles
// - Software can read and write table high byte
// - Store and EEPROM programmable over one data line
// - Debug data two-way, debug clock only input
// - Emulation debug disables other shared pin functions
// - Debug pins still serve as programming pins
// - Four phases per cycle, fetch in first
package pmt_pkg;
	localparam int PM_DEPTH = 8192;
	localparam int PM_AW = 13;
	localparam int PM_DW = 16;
	localparam int DM_AW = 10;
	localparam int EE_AW = 8;
	localparam int EE_DW = 8;
	localparam logic [PM_AW-1:0] RESET_VECTOR = 13'h0000;
	localparam logic [1:0] STD_SECTOR = 2'h0;
	localparam int PTR_HI_W = PM_AW - 8;
	// Serial frame: write flag, target flag, 14 address bits, 16 data bits
	localparam int FRAME_BITS = 32;
	localparam int HEADER_BITS = 16;
	localparam int FRM_WR_BIT = 31;
	localparam int FRM_EE_BIT = 30;
	localparam int CNT_W = 6;
	localparam int SYNC_STAGES = 3;

	// Instruction cycle phases, one clock each
	typedef enum logic [3:0] {
		PMT_T1 = 4'h1,
		PMT_T2 = 4'h2,
		PMT_T3 = 4'h4,
		PMT_T4 = 4'h8
	} pmt_phase_e;

	// Table read progress
	typedef enum logic [2:0] {
		PMT_TB_IDLE = 3'h1,
		PMT_TB_CYC1 = 3'h2,
		PMT_TB_CYC2 = 3'h4
	} pmt_tbl_e;
endpackage

// ### pmt_word_if.sv
// Purpose: Word access path between serial port and program store
// Assumes: Same clock on both sides; req held until ack pulse
// Notes: Pin levels arrive already synchronised
interface pmt_word_if import pmt_pkg::*; ();
	logic ser_clk;
	logic ser_din;
	logic ser_dout;
	logic ser_doe;
	logic active;
	logic req;
	logic wr;
	logic tgt_ee;
	logic [PM_AW-1:0] addr;
	logic [PM_DW-1:0] wdata;
	logic ack;
	logic [PM_DW-1:0] rdata;

	modport port (
		input ser_clk, ser_din, active, ack, rdata,
		output ser_dout, ser_doe, req, wr, tgt_ee, addr, wdata
	);
	modport store (
		output ser_clk, ser_din, active, ack, rdata,
		input ser_dout, ser_doe, req, wr, tgt_ee, addr, wdata
	);
endinterface

// ### pmt_serial_port.sv
// Purpose: Serial programming port turning bit frames into word accesses
// Assumes: Programmer drives the clock; bits sampled on its rising edge
// Notes: Frame is MSB first; reads return 16 bits on the same data line
module pmt_serial_port import pmt_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	pmt_word_if.port wif
);
	logic clk_prev_ff, nxt_clk_prev;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [FRAME_BITS-1:0] shin_ff, nxt_shin;
	logic [PM_DW-1:0] shout_ff, nxt_shout;
	logic req_ff, nxt_req;
	logic rd_phase_ff, nxt_rd_phase;
	logic rise;

	// Frame decode; a dropped enable aborts any half frame
	always_comb
	begin
		rise = wif.ser_clk & ~clk_prev_ff;
		nxt_clk_prev = wif.ser_clk;
		nxt_cnt = cnt_ff;
		nxt_shin = shin_ff;
		nxt_shout = shout_ff;
		nxt_req = req_ff & ~wif.ack;
		nxt_rd_phase = rd_phase_ff;
		if (wif.ack && rd_phase_ff)
			nxt_shout = wif.rdata;
		if (!wif.active)
		begin
			nxt_cnt = '0;
			nxt_req = 1'b0;
			nxt_rd_phase = 1'b0;
		end
		else if (rise)
		begin
			// Address and data share the one line
			nxt_shin = {shin_ff[FRAME_BITS-2:0], wif.ser_din};
			nxt_cnt = cnt_ff + 1'b1;
			if (rd_phase_ff)
				nxt_shout = {shout_ff[PM_DW-2:0], 1'b0};
			if (cnt_ff == CNT_W'(HEADER_BITS - 1) && !shin_ff[HEADER_BITS-2])
			begin
				nxt_req = 1'b1;
				nxt_rd_phase = 1'b1;
			end
			if (cnt_ff == CNT_W'(FRAME_BITS - 1))
			begin
				nxt_cnt = '0;
				nxt_rd_phase = 1'b0;
				nxt_req = shin_ff[FRAME_BITS-2];
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			clk_prev_ff <= 1'b0;
			cnt_ff <= '0;
			shin_ff <= '0;
			shout_ff <= '0;
			req_ff <= 1'b0;
			rd_phase_ff <= 1'b0;
		end
		else
		begin
			clk_prev_ff <= nxt_clk_prev;
			cnt_ff <= nxt_cnt;
			shin_ff <= nxt_shin;
			shout_ff <= nxt_shout;
			req_ff <= nxt_req;
			rd_phase_ff <= nxt_rd_phase;
		end
	end

	// A read header still sits in the low half; a write header has moved up
	assign wif.req = req_ff;
	assign wif.wr = rd_phase_ff ? 1'b0 : shin_ff[FRM_WR_BIT];
	assign wif.tgt_ee = rd_phase_ff ? shin_ff[FRM_EE_BIT-HEADER_BITS] : shin_ff[FRM_EE_BIT];
	assign wif.addr = rd_phase_ff ? shin_ff[PM_AW-1:0] : shin_ff[HEADER_BITS+PM_AW-1:HEADER_BITS];
	assign wif.wdata = shin_ff[PM_DW-1:0];
	assign wif.ser_dout = shout_ff[PM_DW-1];
	assign wif.ser_doe = rd_phase_ff & ~req_ff;
endmodule

// ### pmt_program_memory.sv
// Purpose: Program store with fetch, table read and serial programming access
// Assumes: Core samples phase and strobes; EEPROM answers with ee_ack
// Notes: Shared pins PA0/PA2 are muxed between core, programmer and debugger
module pmt_program_memory import pmt_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic pc_load,
	input wire logic [PM_AW-1:0] pc_load_addr,
	input wire logic tbl_req,
	input wire logic tbl_ext,
	input wire logic [DM_AW-1:0] tbl_dest,
	input wire logic ptr_lo_wr,
	input wire logic ptr_hi_wr,
	input wire logic thb_wr,
	input wire logic [7:0] sw_wdata,
	input wire logic ev_chip,
	input wire logic debug_active,
	input wire logic prog_active,
	input wire logic debug_tx_data,
	input wire logic debug_tx_oe,
	input wire logic gpio_dat_out,
	input wire logic gpio_dat_oe,
	input wire logic gpio_clk_out,
	input wire logic gpio_clk_oe,
	input wire logic pin_data_in,
	input wire logic pin_clock_in,
	input wire logic ee_ack,
	input wire logic [EE_DW-1:0] ee_rdata,
	output logic [3:0] phase_ff,
	output logic [PM_AW-1:0] pc_ff,
	output logic [PM_DW-1:0] instr_ff,
	output logic tbl_busy_ff,
	output logic dm_wr_ff,
	output logic [DM_AW-1:0] dm_addr_ff,
	output logic [7:0] dm_data_ff,
	output logic [7:0] ptr_lo_ff,
	output logic [PTR_HI_W-1:0] ptr_hi_ff,
	output logic [7:0] table_high_byte_ff,
	output logic cpu_hold_ff,
	output logic pin_data_out_ff,
	output logic pin_data_oe_ff,
	output logic pin_clock_out_ff,
	output logic pin_clock_oe_ff,
	output logic gpio_dat_in_ff,
	output logic gpio_clk_in_ff,
	output logic debug_rx_data_ff,
	output logic debug_clk_ff,
	output logic ee_req_ff,
	output logic ee_wr_ff,
	output logic [EE_AW-1:0] ee_addr_ff,
	output logic [EE_DW-1:0] ee_wdata_ff
);
	// Program store
	logic [PM_DW-1:0] mem [PM_DEPTH];
	logic [PM_DW-1:0] mem_rd_ff;
	logic [PM_AW-1:0] mem_addr;
	logic mem_we;

	pmt_phase_e phase_q, nxt_phase;
	pmt_tbl_e tbl_q, nxt_tbl;
	logic [PM_AW-1:0] nxt_pc;
	logic [PM_DW-1:0] nxt_instr, tbl_word_ff, nxt_tbl_word;
	logic [DM_AW-1:0] tbl_dest_ff, nxt_tbl_dest;
	logic nxt_dm_wr;
	logic [DM_AW-1:0] nxt_dm_addr;
	logic [7:0] nxt_dm_data, nxt_ptr_lo, nxt_thb;
	logic [PTR_HI_W-1:0] nxt_ptr_hi;
	logic ser_pm_go, ser_ee_go;
	logic ack_ff, nxt_ack, ee_wait_ff, nxt_ee_wait;
	logic [PM_DW-1:0] ack_data_ff, nxt_ack_data;
	logic nxt_ee_req, nxt_ee_wr;
	logic [EE_AW-1:0] nxt_ee_addr;
	logic [EE_DW-1:0] nxt_ee_wdata;
	logic [SYNC_STAGES-1:0] sd_ff, sc_ff, sp_ff, sg_ff;
	logic dat_st_ff, clk_st_ff, prog_st_ff, dbg_st_ff;
	logic nxt_dat_st, nxt_clk_st, nxt_prog_st, nxt_dbg_st;
	logic dbg_own;
	logic nxt_pdo, nxt_pdoe, nxt_pco, nxt_pcoe, nxt_gdi, nxt_gci, nxt_drx, nxt_dck;
	logic table_read_done;

	pmt_word_if wif ();

	// Table address: pointer high bits above pointer low byte
	function automatic logic [PM_AW-1:0] tbl_addr(input logic [PTR_HI_W-1:0] hi,
		input logic [7:0] lo);
		tbl_addr = {hi, lo};
	endfunction

	// Settled level: follows stage two only once stage three agrees
	function automatic logic settle(input logic [SYNC_STAGES-1:0] s, input logic cur);
		settle = (s[1] == s[2]) ? s[1] : cur;
	endfunction

	// Phase ring; one instruction cycle is four clocks
	always_comb
	begin
		unique case (phase_q)
			PMT_T1: nxt_phase = PMT_T2;
			PMT_T2: nxt_phase = PMT_T3;
			PMT_T3: nxt_phase = PMT_T4;
			PMT_T4: nxt_phase = PMT_T1;
			default: nxt_phase = PMT_T1;
		endcase
	end

	// Store port: fetch in T1, table in T3, serial in T2
	always_comb
	begin
		ser_pm_go = wif.req & ~wif.tgt_ee & ~ack_ff & (phase_q == PMT_T2);
		ser_ee_go = wif.req & wif.tgt_ee & ~ee_wait_ff & ~ack_ff & (phase_q == PMT_T2);
		mem_addr = pc_ff;
		mem_we = 1'b0;
		if (phase_q == PMT_T3 && tbl_q == PMT_TB_CYC1)
			mem_addr = tbl_addr(ptr_hi_ff, ptr_lo_ff);
		else if (ser_pm_go)
		begin
			mem_addr = wif.addr;
			mem_we = wif.wr;
		end
	end

	// Memory has no reset, contents survive like the nonvolatile array
	always_ff @(posedge clock)
	begin
		if (mem_we)
			mem[mem_addr] <= wif.wdata;
		mem_rd_ff <= mem[mem_addr];
	end

	// Fetch, program counter, table read sequence and software registers
	always_comb
	begin
		table_read_done = (tbl_q == PMT_TB_CYC2) && (phase_q == PMT_T4);
		nxt_pc = pc_ff;
		nxt_instr = instr_ff;
		nxt_tbl = tbl_q;
		nxt_tbl_word = tbl_word_ff;
		nxt_tbl_dest = tbl_dest_ff;
		nxt_dm_wr = 1'b0;
		nxt_dm_addr = dm_addr_ff;
		nxt_dm_data = dm_data_ff;
		nxt_ptr_lo = ptr_lo_wr ? sw_wdata : ptr_lo_ff;
		nxt_ptr_hi = ptr_hi_wr ? sw_wdata[PTR_HI_W-1:0] : ptr_hi_ff;
		nxt_thb = thb_wr ? sw_wdata : table_high_byte_ff;
		if (!cpu_hold_ff && phase_q == PMT_T1)
			nxt_pc = pc_ff + 1'b1;
		if (phase_q == PMT_T2)
			nxt_instr = mem_rd_ff;
		if (pc_load && phase_q == PMT_T4)
			nxt_pc = pc_load_addr;
		if (phase_q == PMT_T4 && tbl_q == PMT_TB_CYC1)
			nxt_tbl_word = mem_rd_ff;
		unique case (tbl_q)
			PMT_TB_IDLE:
				if (tbl_req && phase_q == PMT_T4)
				begin
					nxt_tbl = PMT_TB_CYC1;
					// Standard forms are pinned to sector 0
					nxt_tbl_dest = tbl_ext ? tbl_dest : {STD_SECTOR, tbl_dest[7:0]};
				end
			PMT_TB_CYC1:
				if (phase_q == PMT_T4)
					nxt_tbl = PMT_TB_CYC2;
			PMT_TB_CYC2:
				if (phase_q == PMT_T4)
					nxt_tbl = PMT_TB_IDLE;
			default: nxt_tbl = PMT_TB_IDLE;
		endcase
		if (table_read_done)
		begin
			nxt_dm_wr = 1'b1;
			nxt_dm_addr = tbl_dest_ff;
			nxt_dm_data = tbl_word_ff[7:0];
			// Hardware update wins over a software write in the same clock
			nxt_thb = tbl_word_ff[PM_DW-1:8];
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			phase_q <= PMT_T1;
			pc_ff <= RESET_VECTOR;
			instr_ff <= '0;
			tbl_q <= PMT_TB_IDLE;
			tbl_word_ff <= '0;
			tbl_dest_ff <= '0;
			dm_wr_ff <= 1'b0;
			dm_addr_ff <= '0;
			dm_data_ff <= '0;
			ptr_lo_ff <= '0;
			ptr_hi_ff <= '0;
			table_high_byte_ff <= '0;
			phase_ff <= PMT_T1;
			tbl_busy_ff <= 1'b0;
		end
		else
		begin
			phase_q <= nxt_phase;
			pc_ff <= nxt_pc;
			instr_ff <= nxt_instr;
			tbl_q <= nxt_tbl;
			tbl_word_ff <= nxt_tbl_word;
			tbl_dest_ff <= nxt_tbl_dest;
			dm_wr_ff <= nxt_dm_wr;
			dm_addr_ff <= nxt_dm_addr;
			dm_data_ff <= nxt_dm_data;
			ptr_lo_ff <= nxt_ptr_lo;
			ptr_hi_ff <= nxt_ptr_hi;
			table_high_byte_ff <= nxt_thb;
			phase_ff <= nxt_phase;
			tbl_busy_ff <= (nxt_tbl != PMT_TB_IDLE);
		end
	end

	// Serial word accesses: store answers next clock, EEPROM on ee_ack
	always_comb
	begin
		nxt_ack = ser_pm_go | (ee_wait_ff & ee_ack);
		nxt_ack_data = ack_data_ff;
		nxt_ee_wait = ee_wait_ff;
		nxt_ee_req = ser_ee_go;
		nxt_ee_wr = ee_wr_ff;
		nxt_ee_addr = ee_addr_ff;
		nxt_ee_wdata = ee_wdata_ff;
		if (ser_ee_go)
		begin
			nxt_ee_wait = 1'b1;
			nxt_ee_wr = wif.wr;
			nxt_ee_addr = wif.addr[EE_AW-1:0];
			nxt_ee_wdata = wif.wdata[EE_DW-1:0];
		end
		else if (ee_wait_ff && ee_ack)
		begin
			nxt_ee_wait = 1'b0;
			nxt_ack_data = {{(PM_DW-EE_DW){1'b0}}, ee_rdata};
		end
		if (!prog_st_ff)
			nxt_ee_wait = 1'b0;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ack_ff <= 1'b0;
			ack_data_ff <= '0;
			ee_wait_ff <= 1'b0;
			ee_req_ff <= 1'b0;
			ee_wr_ff <= 1'b0;
			ee_addr_ff <= '0;
			ee_wdata_ff <= '0;
		end
		else
		begin
			ack_ff <= nxt_ack;
			ack_data_ff <= nxt_ack_data;
			ee_wait_ff <= nxt_ee_wait;
			ee_req_ff <= nxt_ee_req;
			ee_wr_ff <= nxt_ee_wr;
			ee_addr_ff <= nxt_ee_addr;
			ee_wdata_ff <= nxt_ee_wdata;
		end
	end

	// Store reads bypass the EEPROM data holder
	assign wif.rdata = wif.tgt_ee ? ack_data_ff : mem_rd_ff;
	assign wif.ack = ack_ff;
	assign wif.ser_clk = clk_st_ff;
	assign wif.ser_din = dat_st_ff;
	assign wif.active = prog_st_ff;

	pmt_serial_port u_serial (
		.clock(clock),
		.rst(rst),
		.wif(wif.port)
	);

	// Pin ownership: programmer first, then debugger on the emulation chip
	always_comb
	begin
		nxt_dat_st = settle(sd_ff, dat_st_ff);
		nxt_clk_st = settle(sc_ff, clk_st_ff);
		nxt_prog_st = settle(sp_ff, prog_st_ff);
		nxt_dbg_st = settle(sg_ff, dbg_st_ff);
		dbg_own = ev_chip & dbg_st_ff & ~prog_st_ff;
		nxt_pdo = gpio_dat_out;
		nxt_pdoe = gpio_dat_oe;
		nxt_pco = gpio_clk_out;
		nxt_pcoe = gpio_clk_oe;
		nxt_gdi = dat_st_ff;
		nxt_gci = clk_st_ff;
		nxt_drx = 1'b0;
		nxt_dck = 1'b0;
		if (prog_st_ff)
		begin
			// Clock pin is input only; data line turns for reads
			nxt_pdo = wif.ser_dout;
			nxt_pdoe = wif.ser_doe;
			nxt_pco = 1'b0;
			nxt_pcoe = 1'b0;
			nxt_gdi = 1'b0;
			nxt_gci = 1'b0;
		end
		else if (dbg_own)
		begin
			nxt_pdo = debug_tx_data;
			nxt_pdoe = debug_tx_oe;
			nxt_pco = 1'b0;
			nxt_pcoe = 1'b0;
			nxt_gdi = 1'b0;
			nxt_gci = 1'b0;
			nxt_drx = dat_st_ff;
			nxt_dck = clk_st_ff;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sd_ff <= '0;
			sc_ff <= '0;
			sp_ff <= '0;
			sg_ff <= '0;
			dat_st_ff <= 1'b0;
			clk_st_ff <= 1'b0;
			prog_st_ff <= 1'b0;
			dbg_st_ff <= 1'b0;
			pin_data_out_ff <= 1'b0;
			pin_data_oe_ff <= 1'b0;
			pin_clock_out_ff <= 1'b0;
			pin_clock_oe_ff <= 1'b0;
			gpio_dat_in_ff <= 1'b0;
			gpio_clk_in_ff <= 1'b0;
			debug_rx_data_ff <= 1'b0;
			debug_clk_ff <= 1'b0;
			cpu_hold_ff <= 1'b0;
		end
		else
		begin
			sd_ff <= {sd_ff[1:0], pin_data_in};
			sc_ff <= {sc_ff[1:0], pin_clock_in};
			sp_ff <= {sp_ff[1:0], prog_active};
			sg_ff <= {sg_ff[1:0], debug_active};
			dat_st_ff <= nxt_dat_st;
			clk_st_ff <= nxt_clk_st;
			prog_st_ff <= nxt_prog_st;
			dbg_st_ff <= nxt_dbg_st;
			pin_data_out_ff <= nxt_pdo;
			pin_data_oe_ff <= nxt_pdoe;
			pin_clock_out_ff <= nxt_pco;
			pin_clock_oe_ff <= nxt_pcoe;
			gpio_dat_in_ff <= nxt_gdi;
			gpio_clk_in_ff <= nxt_gci;
			debug_rx_data_ff <= nxt_drx;
			debug_clk_ff <= nxt_dck;
			cpu_hold_ff <= nxt_prog_st; // Core frozen while store is rewritten
		end
	end
endmodule

// ### pmt_props.sv
// Purpose: Port timing checks of the program memory access block
// Assumes: One clock domain, asynchronous active high reset
// Notes: Bound to the top module from the bench top file
module pmt_props import pmt_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic tbl_req,
	input wire logic tbl_ext,
	input wire logic [DM_AW-1:0] tbl_dest,
	input wire logic thb_wr,
	input wire logic [7:0] sw_wdata,
	input wire logic ev_chip,
	input wire logic debug_active,
	input wire logic prog_active,
	input wire logic [3:0] phase_ff,
	input wire logic [PM_AW-1:0] pc_ff,
	input wire logic tbl_busy_ff,
	input wire logic dm_wr_ff,
	input wire logic [DM_AW-1:0] dm_addr_ff,
	input wire logic [7:0] table_high_byte_ff,
	input wire logic cpu_hold_ff,
	input wire logic pin_clock_oe_ff,
	input wire logic gpio_dat_in_ff,
	input wire logic gpio_clk_in_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Expected next phase, kept apart so the past value is a plain signal
	wire logic [3:0] rot = {phase_ff[2:0], phase_ff[3]};
	// A table read is taken only in the last phase while idle
	sequence s_take;
		tbl_req && phase_ff == 4'h8 && !tbl_busy_ff;
	endsequence
	sequence s_run;
		tbl_busy_ff [*8];
	endsequence
	property p_phase;
		1'b1 |=> phase_ff == $past(rot);
	endproperty
	a_phase: assert property (p_phase) else $error("phase did not rotate");
	property p_len;
		s_take |=> s_run ##1 dm_wr_ff;
	endproperty
	a_len: assert property (p_len) else $error("table read length wrong");
	// Standard form forces the sector, extended form keeps it
	property p_dest;
		logic [DM_AW-1:0] d;
		(s_take, d = tbl_ext ? tbl_dest : {STD_SECTOR, tbl_dest[7:0]})
			|=> ##8 dm_wr_ff && dm_addr_ff == d;
	endproperty
	a_dest: assert property (p_dest) else $error("table destination wrong");
	property p_thb;
		thb_wr && !tbl_busy_ff |=> table_high_byte_ff == $past(sw_wdata);
	endproperty
	a_thb: assert property (p_thb) else $error("high byte write lost");
	property p_boot;
		$fell(rst) |-> pc_ff == RESET_VECTOR ##1 pc_ff == RESET_VECTOR + 13'h1;
	endproperty
	a_boot: assert property (p_boot) else $error("fetch did not start at zero");
	property p_fetch;
		phase_ff == 4'h1 && !cpu_hold_ff |=> pc_ff == $past(pc_ff) + 13'h1;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address not advanced");
	property p_hold;
		cpu_hold_ff && phase_ff == 4'h1 |=> $stable(pc_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("core ran while held");
	property p_prog;
		prog_active [*6] |-> !pin_clock_oe_ff && !gpio_dat_in_ff && !gpio_clk_in_ff;
	endproperty
	a_prog: assert property (p_prog) else $error("pins not given to programmer");
	property p_dbg;
		(ev_chip && debug_active) [*6] |-> !pin_clock_oe_ff && !gpio_dat_in_ff && !gpio_clk_in_ff;
	endproperty
	a_dbg: assert property (p_dbg) else $error("shared pin functions active");
endmodule

// ### pmt_prog_model.sv
// Purpose: Programmer model driving the serial clock and data pins
// Assumes: Clock half period of ten system clocks, well above the sync delay
// Notes: Clock rests low between frames; a released data line shows the inverse bit
module pmt_prog_model (
	input wire logic clock,
	input wire logic dev_out,
	input wire logic dev_oe,
	output logic pin_clock,
	output logic pin_data,
	output logic prog_active
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv_en = 1'b0;
	logic drv_val = 1'b0;
	// Idle levels
	initial
	begin
		pin_clock = 1'b0;
		prog_active = 1'b0;
	end
	// Shared data wire: the device wins while it drives
	assign pin_data = dev_oe ? dev_out : (drv_en ? drv_val : ~drv_val);
	task automatic half();
		repeat (10) @(posedge clock);
		#1;
	endtask
	// One word frame; read data is taken just before each rising edge
	task automatic frame(input logic [31:0] f, output logic [15:0] rd);
		prog_active = 1'b1;
		half();
		for (int i = 31; i >= 0; i--)
		begin
			drv_en = (i > 15) || f[31];
			drv_val = f[i];
			half();
			if (i < 16)
				rd[i] = pin_data;
			pin_clock = 1'b1;
			half();
			pin_clock = 1'b0;
		end
		drv_en = 1'b0;
		repeat (4) half();
	endtask
	task automatic done();
		prog_active = 1'b0;
		half();
	endtask
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench of the program memory access block
// Assumes: Store image is loaded serially before table reads
// Notes: A small EEPROM stand-in answers requests in the same clock they are raised
module tb_top import pmt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic pc_load = 1'b0, tbl_req = 1'b0, tbl_ext = 1'b0, ee_ack = 1'b0;
	logic ptr_lo_wr = 1'b0, ptr_hi_wr = 1'b0, thb_wr = 1'b0, ev_chip = 1'b0;
	logic debug_active = 1'b0, debug_tx_data = 1'b0, debug_tx_oe = 1'b0;
	logic gpio_dat_out = 1'b0, gpio_dat_oe = 1'b0, gpio_clk_out = 1'b0, gpio_clk_oe = 1'b0;
	logic [PM_AW-1:0] pc_load_addr = 13'h0000;
	logic [DM_AW-1:0] tbl_dest = 10'h000;
	logic [7:0] sw_wdata = 8'h00, ee_rdata = 8'h5c;
	logic [15:0] ee_cap = 16'h0000;
	wire logic prog_active, pin_data_in, pin_clock_in;
	wire logic [3:0] phase_ff;
	wire logic [PM_AW-1:0] pc_ff;
	wire logic [15:0] instr_ff;
	wire logic [DM_AW-1:0] dm_addr_ff;
	wire logic [7:0] dm_data_ff, ptr_lo_ff, table_high_byte_ff, ee_addr_ff, ee_wdata_ff;
	wire logic [PTR_HI_W-1:0] ptr_hi_ff;
	wire logic dm_wr_ff, cpu_hold_ff, pin_data_out_ff, pin_data_oe_ff;
	wire logic gpio_dat_in_ff, ee_req_ff, ee_wr_ff, debug_rx_data_ff;
	int fail_count = 0;
	int check_count = 0;
	pmt_program_memory uut (.clock, .rst, .pc_load, .pc_load_addr, .tbl_req, .tbl_ext,
		.tbl_dest, .ptr_lo_wr, .ptr_hi_wr, .thb_wr, .sw_wdata, .ev_chip, .debug_active,
		.prog_active, .debug_tx_data, .debug_tx_oe, .gpio_dat_out, .gpio_dat_oe,
		.gpio_clk_out, .gpio_clk_oe, .pin_data_in, .pin_clock_in, .ee_ack, .ee_rdata,
		.phase_ff, .pc_ff, .instr_ff, .tbl_busy_ff(), .dm_wr_ff, .dm_addr_ff, .dm_data_ff,
		.ptr_lo_ff, .ptr_hi_ff, .table_high_byte_ff, .cpu_hold_ff, .pin_data_out_ff,
		.pin_data_oe_ff, .pin_clock_out_ff(), .pin_clock_oe_ff(), .gpio_dat_in_ff,
		.gpio_clk_in_ff(), .debug_rx_data_ff, .debug_clk_ff(), .ee_req_ff, .ee_wr_ff,
		.ee_addr_ff, .ee_wdata_ff);
	pmt_prog_model u_prog (.clock, .dev_out(pin_data_out_ff), .dev_oe(pin_data_oe_ff),
		.pin_clock(pin_clock_in), .pin_data(pin_data_in), .prog_active);
	always #2.5 clock = ~clock;
	// EEPROM stand-in: acknowledge each request in the same clock, 1 ns after it rises
	always @(posedge clock)
	begin
		#1;
		ee_ack = ee_req_ff;
		if (ee_req_ff && ee_wr_ff)
			ee_cap = {ee_addr_ff, ee_wdata_ff};
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic t_reset();
		cyc(2);
		chk(16'({phase_ff, pc_ff}), 16'h0000 | 16'h2000);
		cyc(3);
		rst = 1'b0;
		cyc(1);
		chk(16'(phase_ff), 16'h0002);
	endtask
	// Load the store, read a word back with debug enabled, then write and read the EEPROM
	task automatic t_program();
		logic [15:0] rd;
		u_prog.frame({2'b10, 14'h1f06, 16'h1a2b}, rd);
		chk(16'(cpu_hold_ff), 16'h0001);
		u_prog.frame({2'b10, 14'h1f05, 16'h0f0e}, rd);
		u_prog.frame({2'b10, 14'h0000, 16'h3c5a}, rd);
		ev_chip = 1'b1;
		debug_active = 1'b1;
		u_prog.frame({2'b00, 14'h1f06, 16'h0000}, rd);
		chk(rd, 16'h1a2b);
		u_prog.frame({2'b11, 14'h0042, 16'h00a5}, rd);
		chk(ee_cap, 16'h42a5);
		u_prog.frame({2'b01, 14'h0042, 16'h0000}, rd);
		chk(rd, 16'h005c);
		u_prog.done();
		ev_chip = 1'b0;
		debug_active = 1'b0;
		cyc(8);
	endtask
	// Request held high: ignored while busy, retaken at the next idle last phase
	task automatic t_table();
		sw_wdata = 8'h06;
		ptr_lo_wr = 1'b1;
		cyc(1);
		ptr_lo_wr = 1'b0;
		sw_wdata = 8'h1f;
		ptr_hi_wr = 1'b1;
		cyc(1);
		ptr_hi_wr = 1'b0;
		chk(16'({ptr_hi_ff, ptr_lo_ff}), 16'h1f06);
		repeat (4) if (phase_ff !== 4'h8) cyc(1);
		tbl_req = 1'b1;
		tbl_dest = 10'h345;
		for (int n = 1; n <= 21; n++)
		begin
			cyc(1);
			sw_wdata = 8'h05;
			ptr_lo_wr = (n == 5);
			tbl_ext = tbl_ext | (n == 5);
			if (n == 9)
			begin
				chk(16'({dm_wr_ff, dm_addr_ff}), 16'h0445);
				chk({table_high_byte_ff, dm_data_ff}, 16'h1a2b);
			end
			if (n == 10)
				chk(16'(dm_wr_ff), 16'h0000);
			if (n == 13)
				tbl_req = 1'b0;
		end
		chk(16'({dm_wr_ff, dm_addr_ff}), 16'h0745);
		chk({table_high_byte_ff, dm_data_ff}, 16'h0f0e);
	endtask
	task automatic t_swreg();
		sw_wdata = 8'h77;
		thb_wr = 1'b1;
		cyc(1);
		thb_wr = 1'b0;
		chk(16'(table_high_byte_ff), 16'h0077);
	endtask
	// Debug owner overrides the shared function, then the core gets the pin back
	task automatic t_pins();
		ev_chip = 1'b1;
		debug_active = 1'b1;
		debug_tx_oe = 1'b1;
		debug_tx_data = 1'b1;
		gpio_dat_oe = 1'b1;
		gpio_dat_out = 1'b1;
		gpio_clk_oe = 1'b1;
		cyc(8);
		chk(16'({pin_data_oe_ff, pin_data_out_ff, gpio_dat_in_ff, debug_rx_data_ff}), 16'h000d);
		ev_chip = 1'b0;
		cyc(8);
		chk(16'({pin_data_oe_ff, pin_data_out_ff, gpio_dat_in_ff, debug_rx_data_ff}), 16'h000e);
	endtask
	// Reset in mid-run restarts fetching from the reset vector
	task automatic t_boot();
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		repeat (8) if (phase_ff !== 4'h4) cyc(1);
		chk(instr_ff, 16'h3c5a);
		// Branch taken in the last phase, fetched in the next cycle
		pc_load_addr = 13'h1f05;
		pc_load = 1'b1;
		cyc(2);
		pc_load = 1'b0;
		cyc(2);
		chk(instr_ff, 16'h0f0e);
		chk(16'(pc_ff), 16'h1f06);
	endtask
	initial
	begin
		t_reset();
		t_program();
		t_table();
		t_swreg();
		t_pins();
		t_boot();
		conclude();
	end
	// Watchdog cuts a hang short
	initial
	begin
		#100us;
		fail_count++;
		conclude();
	end
endmodule
bind pmt_program_memory pmt_props u_props (.clock, .rst, .tbl_req, .tbl_ext, .tbl_dest,
	.thb_wr, .sw_wdata, .ev_chip, .debug_active, .prog_active, .phase_ff, .pc_ff,
	.tbl_busy_ff, .dm_wr_ff, .dm_addr_ff, .table_high_byte_ff, .cpu_hold_ff,
	.pin_clock_oe_ff, .gpio_dat_in_ff, .gpio_clk_in_ff);
